// File: test/sld_lamp_viewer.sv
// partner model: one front panel lamp as the installer sees it
// assumes lamp levels are active high and stable between pclk edges
`timescale 1ns/100ps
`default_nettype none

module sld_lamp_viewer (
  input  wire logic       pclk,
  input  wire logic       clr,
  input  wire logic       lamp,
  output logic [7:0]      flips
);
  logic       lit_r;
  logic [7:0] flips_nxt;

  // an emitter just follows its drive; a seen flip is a blink edge
  always_comb begin
    flips_nxt = flips;
    if (clr) begin
      flips_nxt = 8'h00;
    end else if (lamp != lit_r) begin
      flips_nxt = flips + 8'h01;
    end
  end

  always_ff @(posedge pclk) begin
    lit_r <= lamp;
    flips <= flips_nxt;
  end
endmodule

`default_nettype wire

// File: test/sld_status_lamps_properties.sv
// port assertions for the status lamp driver
// assumes it is bound onto sld_status_lamps
`timescale 1ns/100ps
`default_nettype none

module sld_status_lamps_checker #(
  parameter int unsigned BLINK_HALF_CYC = 8
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       boot_done,
  input wire logic       aiming_mode,
  input wire logic       sync_ok,
  input wire logic [1:0] reg_state,
  input wire logic       link_up,
  input wire logic [1:0] link_speed,
  input wire logic       optical_link_up,
  input wire logic       power_indicator_yellow,
  input wire logic       power_indicator_blue,
  input wire logic       sync_lamp,
  input wire logic       session_lamp,
  input wire logic       spare_bar_lamp,
  input wire logic       combined_session_lamp_green,
  input wire logic       combined_session_lamp_yellow,
  input wire logic       wired_link_lamp_red,
  input wire logic       wired_link_lamp_green,
  input wire logic       optical_port_lamp
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****
  // lamps
  // ****
  power_one_a: assert property (power_indicator_yellow ^ power_indicator_blue)
    else $error("power lamp not singly lit");
  boot_yellow_a: assert property (power_indicator_yellow |-> !$past(boot_done))
    else $error("yellow power after boot");
  booted_blue_a: assert property ($past(presetn) && $past(boot_done) |-> power_indicator_blue)
    else $error("no blue power after boot");
  wired_red_a: assert property (wired_link_lamp_red |-> $past(link_up) && !$past(link_speed[0]))
    else $error("red wired lamp at wrong speed");
  wired_green_a: assert property (wired_link_lamp_green |-> $past(link_up) &&
    ($past(link_speed) == 2'h1 || $past(link_speed) == 2'h2)) else $error("green wired lamp at wrong speed");
  optical_follow_a: assert property ($past(presetn) |-> optical_port_lamp == $past(optical_link_up))
    else $error("optical lamp not following link");
  sync_follow_a: assert property (sync_lamp && !$past(aiming_mode) |-> $past(sync_ok))
    else $error("sync lamp without sync");
  bar_order_a: assert property (spare_bar_lamp |-> sync_lamp && session_lamp && $past(aiming_mode))
    else $error("bar graph out of order");
  comb_yellow_a: assert property (combined_session_lamp_yellow && !$past(aiming_mode) |->
    $past(reg_state) == 2'h2 && !combined_session_lamp_green) else $error("yellow session lamp unregistered");
  comb_green_a: assert property (combined_session_lamp_green && !$past(aiming_mode) |->
    $past(reg_state) <= 2'h1) else $error("green session lamp when registered");

  // ****
  // register port
  // ****
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  apb_pulse_a: assert property (pready |=> !pready && !pslverr)
    else $error("apb answer held");

  cover property (spare_bar_lamp);
  cover property (combined_session_lamp_green ##1 !combined_session_lamp_green);
  cover property (pready && pslverr);
endmodule

bind sld_status_lamps sld_status_lamps_checker #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_chk (.*);

`default_nettype wire

// File: test/sld_status_lamps_tb.sv
// self-checking bench for the status lamp driver
// assumes sld_pkg and the design are compiled first
`timescale 1ns/100ps
`default_nettype none

module sld_status_lamps_tb;
  logic        pclk, presetn, psel, penable, pwrite, vclr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, e, boot_done, aiming_mode, sync_ok;
  logic        link_up, frame_activity, optical_link_up;
  logic [1:0]  reg_state, link_speed;
  logic [7:0]  rx_power, wflips, cflips;
  wire  [9:0]  lamps;
  int          num_errors, tests_run, cyc;

  sld_status_lamps #(.BLINK_HALF_CYC(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_done(boot_done), .aiming_mode(aiming_mode),
    .sync_ok(sync_ok), .reg_state(reg_state), .rx_power(rx_power), .link_up(link_up),
    .link_speed(link_speed), .frame_activity(frame_activity), .optical_link_up(optical_link_up),
    .power_indicator_yellow(lamps[0]), .power_indicator_blue(lamps[1]), .sync_lamp(lamps[2]),
    .session_lamp(lamps[3]), .spare_bar_lamp(lamps[4]), .combined_session_lamp_green(lamps[5]),
    .combined_session_lamp_yellow(lamps[6]), .wired_link_lamp_red(lamps[7]),
    .wired_link_lamp_green(lamps[8]), .optical_port_lamp(lamps[9]));
  sld_lamp_viewer u_wv (.pclk(pclk), .clr(vclr), .lamp(lamps[7] | lamps[8]), .flips(wflips));
  sld_lamp_viewer u_cv (.pclk(pclk), .clr(vclr), .lamp(lamps[5]), .flips(cflips));

  // ****
  // helpers
  // ****
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; holds the request until pready, only the run timeout cuts a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 2); // one wait state per access
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(d, x);
    chk(e, xe);
  endtask

  task automatic wrr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
    chk(e, 0);
  endtask

  // registered lamps show a change one edge after it is driven; lm waits three
  task automatic lm(input logic [9:0] m, input logic [9:0] x);
    repeat (3) @(posedge pclk);
    chk(lamps & m, x);
  endtask

  task automatic vclear();
    vclr <= 1'b1;
    @(posedge pclk);
    vclr <= 1'b0;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    rdc(sld_pkg::ADDR_CTRL, 32'h0, 0);
    rdc(sld_pkg::ADDR_THR_LOW, 32'(sld_pkg::THR_LOW_RESET), 0);
    rdc(sld_pkg::ADDR_THR_MID, 32'(sld_pkg::THR_MID_RESET), 0);
    rdc(sld_pkg::ADDR_THR_TOP, 32'(sld_pkg::THR_TOP_RESET), 0);
    rdc(sld_pkg::ADDR_THR_NRM, 32'(sld_pkg::THR_NRM_RESET), 0);
    rdc(12'h018, 32'h0, 1);
    apb(1'b1, 12'h018, 32'h1);
    chk(e, 1);
    wrr(sld_pkg::ADDR_STATUS, 32'hffffffff);
  endtask

  task automatic t_power();
    lm(10'h003, 10'h002);
    wrr(sld_pkg::ADDR_CTRL, 32'h2);
    lm(10'h003, 10'h001);
    boot_done <= 1'b1;
    lm(10'h003, 10'h002);
  endtask

  task automatic t_wired();
    logic [9:0] ex [4];
    ex = '{10'h080, 10'h100, 10'h180, 10'h000};
    link_up <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      link_speed <= 2'(s);
      lm(10'h180, ex[s]);
    end
    link_up <= 1'b0;
    link_speed <= sld_pkg::SPEED_1000M;
    lm(10'h180, 10'h000);
  endtask

  task automatic t_act();
    link_up <= 1'b1;
    link_speed <= sld_pkg::SPEED_100M;
    vclear();
    frame_activity <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(wflips >= 2, 1);
    frame_activity <= 1'b0;
    repeat (50) @(posedge pclk);
    lm(10'h180, 10'h100);
  endtask

  task automatic t_bar();
    logic [7:0] rx [6];
    logic [1:0] lv [6];
    logic [9:0] br [4];
    rx = '{8'h3f, 8'h40, 8'h7f, 8'h80, 8'hbf, 8'hc0};
    lv = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    br = '{10'h000, 10'h004, 10'h00c, 10'h01c};
    wrr(sld_pkg::ADDR_CTRL, 32'h0);
    aiming_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rx_power <= rx[i];
      lm(10'h01c, br[lv[i]]);
      apb(1'b0, sld_pkg::ADDR_STATUS, 32'h0);
      chk(d[11:10], lv[i]);
    end
    wrr(sld_pkg::ADDR_THR_LOW, 32'hffffff50);
    rdc(sld_pkg::ADDR_THR_LOW, 32'h50, 0);
    rx_power <= 8'h4f;
    lm(10'h01c, 10'h000);
    rx_power <= 8'h50;
    lm(10'h01c, 10'h004);
  endtask

  task automatic t_sync_opt();
    aiming_mode <= 1'b0;
    sync_ok <= 1'b0;
    reg_state <= 2'h2;
    optical_link_up <= 1'b1;
    lm(10'h21c, 10'h208);
    sync_ok <= 1'b1;
    reg_state <= 2'h1;
    lm(10'h21c, 10'h204);
    aiming_mode <= 1'b1;
    rx_power <= 8'h00;
    optical_link_up <= 1'b0;
    lm(10'h200, 10'h000);
    optical_link_up <= 1'b1;
    lm(10'h200, 10'h200);
  endtask

  task automatic t_single();
    wrr(sld_pkg::ADDR_CTRL, 32'h1);
    aiming_mode <= 1'b0;
    reg_state <= 2'h0;
    lm(10'h05c, 10'h000);
    vclear();
    repeat (40) @(posedge pclk);
    chk(cflips >= 4, 1);
    reg_state <= 2'h1;
    lm(10'h060, 10'h020);
    vclear();
    repeat (20) @(posedge pclk);
    chk(cflips, 0);
    reg_state <= 2'h2;
    lm(10'h07c, 10'h040);
    reg_state <= 2'h3;
    lm(10'h060, 10'h000);
    aiming_mode <= 1'b1;
    rx_power <= sld_pkg::THR_NRM_RESET;
    lm(10'h060, 10'h020);
    rx_power <= sld_pkg::THR_NRM_RESET + 8'h01;
    lm(10'h060, 10'h040);
  endtask

  // ****
  // run
  // ****
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // whole run is a few hundred cycles; this only cuts a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("[ERR] %0t run did not finish", $time);
      test_done();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, vclr} = '0;
    {boot_done, aiming_mode, sync_ok, reg_state, rx_power} = '0;
    {link_up, link_speed, frame_activity, optical_link_up} = '0;
    repeat (5) @(posedge pclk);
    chk(lamps, 10'h002);
    presetn <= 1'b1;
    t_regs();
    t_power();
    t_wired();
    t_act();
    t_bar();
    t_sync_opt();
    t_single();
    test_done();
  end
endmodule

`default_nettype wire

// File: verilog/sld_blink_gen.sv
// free-running blink phase generator for the status lamps
// assumes one clock; half period is given in pclk cycles
`timescale 1ns/100ps
`default_nettype none

module sld_blink_gen #(
  parameter int unsigned HALF_CYC = sld_pkg::BLINK_HALF_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      phase,
  output logic      tick
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        phase_r;
  logic        phase_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt  = (cnt_r == 32'(HALF_CYC - 1));
    cnt_nxt   = tick_nxt ? 32'h0 : cnt_r + 32'h1;
    phase_nxt = tick_nxt ? ~phase_r : phase_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 32'h0;
      phase_r <= 1'b0;
      tick_r  <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign phase = phase_r;
  assign tick  = tick_r;

endmodule

`default_nettype wire

// File: verilog/sld_pkg.sv
// constants shared by the status lamp driver and its blink timer
// assumes a 125 MHz pclk and a 32-bit apb register port
`default_nettype none

package sld_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [1:0]  ACT_HOLD_TICKS = 2'h2;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_THR_LOW = 12'h004;
  localparam logic [11:0] ADDR_THR_MID = 12'h008;
  localparam logic [11:0] ADDR_THR_TOP = 12'h00c;
  localparam logic [11:0] ADDR_THR_NRM = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;

  // ctrl fields
  localparam int unsigned CTRL_SINGLE_BIT  = 0;
  localparam int unsigned CTRL_BICOLOR_BIT = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h0;

  // threshold reset values
  localparam logic [7:0] THR_LOW_RESET = 8'h40;
  localparam logic [7:0] THR_MID_RESET = 8'h80;
  localparam logic [7:0] THR_TOP_RESET = 8'hc0;
  localparam logic [7:0] THR_NRM_RESET = 8'h80;

  // status fields
  localparam int unsigned ST_POWER_YEL = 0;
  localparam int unsigned ST_POWER_BLU = 1;
  localparam int unsigned ST_SYNC      = 2;
  localparam int unsigned ST_SESSION   = 3;
  localparam int unsigned ST_SPARE     = 4;
  localparam int unsigned ST_COMB_GRN  = 5;
  localparam int unsigned ST_COMB_YEL  = 6;
  localparam int unsigned ST_WIRED_RED = 7;
  localparam int unsigned ST_WIRED_GRN = 8;
  localparam int unsigned ST_OPTICAL   = 9;
  localparam int unsigned ST_BAR_LSB   = 10;
  localparam int unsigned ST_ACTIVITY  = 12;

  // ****************************************
  // input encodings
  // ****************************************
  localparam logic [1:0] SPEED_10M   = 2'h0;
  localparam logic [1:0] SPEED_100M  = 2'h1;
  localparam logic [1:0] SPEED_1000M = 2'h2;

  typedef enum logic [1:0] {
    SLD_REG_SCANNING,
    SLD_REG_REGISTERING,
    SLD_REG_REGISTERED
  } sld_reg_state_t;

endpackage

`default_nettype wire

// File: verilog/sld_status_lamps.sv
// status lamp driver: maps unit status onto front panel lamps
// assumes status inputs synchronous to pclk and an apb master
//
// Notes on behaviour
// [RULE_01] power lamp always lit after reset
// [RULE_02] bicolour power: yellow booting, blue booted
// [RULE_03] wired colour: red 10M, green 100M, orange 1G
// [RULE_04] wired lamp blinks during frame activity
// [RULE_05] single lamp blinks green while scanning
// [RULE_06] single lamp solid green while registering
// [RULE_07] single lamp solid yellow once registered
// [RULE_08] aiming single lamp: green below, yellow above
// [RULE_09] aiming three lamps form power bar graph
// [RULE_10] sync lamp follows sync state in operation
// [RULE_11] optical lamp green while optical link up
// [RULE_12] bar level from three ascending thresholds
`timescale 1ns/100ps
`default_nettype none

module sld_status_lamps #(
  parameter int unsigned BLINK_HALF_CYC = sld_pkg::BLINK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // unit status
  input  wire logic        boot_done,
  input  wire logic        aiming_mode,
  input  wire logic        sync_ok,
  input  wire logic [1:0]  reg_state,
  input  wire logic [7:0]  rx_power,
  input  wire logic        link_up,
  input  wire logic [1:0]  link_speed,
  input  wire logic        frame_activity,
  input  wire logic        optical_link_up,
  // lamps
  output logic             power_indicator_yellow,
  output logic             power_indicator_blue,
  output logic             sync_lamp,
  output logic             session_lamp,
  output logic             spare_bar_lamp,
  output logic             combined_session_lamp_green,
  output logic             combined_session_lamp_yellow,
  output logic             wired_link_lamp_red,
  output logic             wired_link_lamp_green,
  output logic             optical_port_lamp
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] bar_level(input logic [7:0] power_indicator, input logic [7:0] t0,
                                           input logic [7:0] t1,  input logic [7:0] t2);
    logic [1:0] lvl;
    lvl = 2'h0;
    if (power_indicator >= t0) lvl = 2'h1;
    if (power_indicator >= t1) lvl = 2'h2;
    if (power_indicator >= t2) lvl = 2'h3;
    return lvl;
  endfunction

  function automatic logic [31:0] pad8(input logic [7:0] v);
    return {24'h0, v};
  endfunction

  // ****************************************
  // blink timing
  // ****************************************
  logic blink_phase;
  logic blink_tick;

  sld_blink_gen #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (blink_phase),
    .tick    (blink_tick)
  );

  // ****************************************
  // apb register file
  // ****************************************
  logic [1:0]  ctrl_r;
  logic [1:0]  ctrl_nxt;
  logic [7:0]  thr_low_r;
  logic [7:0]  thr_low_nxt;
  logic [7:0]  thr_mid_r;
  logic [7:0]  thr_mid_nxt;
  logic [7:0]  thr_top_r;
  logic [7:0]  thr_top_nxt;
  logic [7:0]  thr_nrm_r;
  logic [7:0]  thr_nrm_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] status_word;
  logic        wr_commit;
  logic        addr_hit;

  // one wait state keeps prdata and pready straight from flops
  always_comb begin
    ctrl_nxt    = ctrl_r;
    thr_low_nxt = thr_low_r;
    thr_mid_nxt = thr_mid_r;
    thr_top_nxt = thr_top_r;
    thr_nrm_nxt = thr_nrm_r;
    prdata_nxt  = 32'h0;
    pslverr_nxt = 1'b0;
    pready_nxt  = psel && penable && !pready_r;
    wr_commit   = psel && penable && pready_r && pwrite;
    addr_hit    = 1'b1;
    case (paddr)
      sld_pkg::ADDR_CTRL:    prdata_nxt = {30'h0, ctrl_r};
      sld_pkg::ADDR_THR_LOW: prdata_nxt = pad8(thr_low_r);
      sld_pkg::ADDR_THR_MID: prdata_nxt = pad8(thr_mid_r);
      sld_pkg::ADDR_THR_TOP: prdata_nxt = pad8(thr_top_r);
      sld_pkg::ADDR_THR_NRM: prdata_nxt = pad8(thr_nrm_r);
      sld_pkg::ADDR_STATUS:  prdata_nxt = status_word;
      default:               addr_hit   = 1'b0;
    endcase
    prdata_nxt  = (pready_nxt && !pwrite) ? prdata_nxt : 32'h0;
    pslverr_nxt = pready_nxt && !addr_hit;
    if (wr_commit) begin
      case (paddr)
        sld_pkg::ADDR_CTRL:    ctrl_nxt    = pwdata[1:0];
        sld_pkg::ADDR_THR_LOW: thr_low_nxt = pwdata[7:0];
        sld_pkg::ADDR_THR_MID: thr_mid_nxt = pwdata[7:0];
        sld_pkg::ADDR_THR_TOP: thr_top_nxt = pwdata[7:0];
        sld_pkg::ADDR_THR_NRM: thr_nrm_nxt = pwdata[7:0];
        default:               ctrl_nxt    = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= sld_pkg::CTRL_RESET;
      thr_low_r <= sld_pkg::THR_LOW_RESET;
      thr_mid_r <= sld_pkg::THR_MID_RESET;
      thr_top_r <= sld_pkg::THR_TOP_RESET;
      thr_nrm_r <= sld_pkg::THR_NRM_RESET;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      thr_low_r <= thr_low_nxt;
      thr_mid_r <= thr_mid_nxt;
      thr_top_r <= thr_top_nxt;
      thr_nrm_r <= thr_nrm_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ****************************************
  // activity stretch
  // ****************************************
  // a single frame may be far shorter than a blink, so hold it
  logic [1:0] act_cnt_r;
  logic [1:0] act_cnt_nxt;
  logic       act_busy;

  always_comb begin
    act_busy    = (act_cnt_r != 2'h0);
    act_cnt_nxt = act_cnt_r;
    if (frame_activity) begin
      act_cnt_nxt = sld_pkg::ACT_HOLD_TICKS;                       // [RULE_04]
    end else if (blink_tick && act_busy) begin
      act_cnt_nxt = act_cnt_r - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cnt_r <= 2'h0;
    end else begin
      act_cnt_r <= act_cnt_nxt;
    end
  end

  // ****************************************
  // lamp mapping
  // ****************************************
  logic       pwr_yel_r;
  logic       pwr_yel_nxt;
  logic       pwr_blu_r;
  logic       pwr_blu_nxt;
  logic       sync_r;
  logic       sync_nxt;
  logic       sess_r;
  logic       sess_nxt;
  logic       spare_r;
  logic       spare_nxt;
  logic       comb_grn_r;
  logic       comb_grn_nxt;
  logic       comb_yel_r;
  logic       comb_yel_nxt;
  logic       wred_r;
  logic       wred_nxt;
  logic       wgrn_r;
  logic       wgrn_nxt;
  logic       opt_r;
  logic       opt_nxt;
  logic [1:0] bar_r;
  logic [1:0] bar_nxt;
  logic       single_var;
  logic       bicolor;
  logic       wired_on;

  always_comb begin
    single_var = ctrl_r[sld_pkg::CTRL_SINGLE_BIT];
    bicolor    = ctrl_r[sld_pkg::CTRL_BICOLOR_BIT];
    bar_nxt    = bar_level(rx_power, thr_low_r, thr_mid_r, thr_top_r); // [RULE_12]
    // power lamp never goes dark
    pwr_yel_nxt = bicolor && !boot_done;                            // [RULE_01] [RULE_02]
    pwr_blu_nxt = !bicolor || boot_done;                            // [RULE_01] [RULE_02]
    // wired link: orange is red and green together
    wired_on = link_up && !(act_busy && !blink_phase);              // [RULE_04]
    wred_nxt = 1'b0;
    wgrn_nxt = 1'b0;
    case (link_speed)
      sld_pkg::SPEED_10M:   wred_nxt = wired_on;                    // [RULE_03]
      sld_pkg::SPEED_100M:  wgrn_nxt = wired_on;                    // [RULE_03]
      sld_pkg::SPEED_1000M: begin
        wred_nxt = wired_on;                                        // [RULE_03]
        wgrn_nxt = wired_on;
      end
      default:              wred_nxt = 1'b0;
    endcase
    opt_nxt = optical_link_up;                                      // [RULE_11]
    sync_nxt     = 1'b0;
    sess_nxt     = 1'b0;
    spare_nxt    = 1'b0;
    comb_grn_nxt = 1'b0;
    comb_yel_nxt = 1'b0;
    if (single_var) begin
      if (aiming_mode) begin
        comb_yel_nxt = (rx_power > thr_nrm_r);                      // [RULE_08]
        comb_grn_nxt = !(rx_power > thr_nrm_r);                     // [RULE_08]
      end else begin
        case (reg_state)
          sld_pkg::SLD_REG_SCANNING:    comb_grn_nxt = blink_phase; // [RULE_05]
          sld_pkg::SLD_REG_REGISTERING: comb_grn_nxt = 1'b1;        // [RULE_06]
          sld_pkg::SLD_REG_REGISTERED:  comb_yel_nxt = 1'b1;        // [RULE_07]
          default:                      comb_grn_nxt = 1'b0;
        endcase
      end
    end else if (aiming_mode) begin
      sync_nxt  = (bar_nxt >= 2'h1);                                // [RULE_09]
      sess_nxt  = (bar_nxt >= 2'h2);                                // [RULE_09]
      spare_nxt = (bar_nxt == 2'h3);                                // [RULE_09]
    end else begin
      sync_nxt = sync_ok;                                           // [RULE_10]
      sess_nxt = (reg_state == sld_pkg::SLD_REG_REGISTERED);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_yel_r  <= 1'b0;
      pwr_blu_r  <= 1'b1;
      sync_r     <= 1'b0;
      sess_r     <= 1'b0;
      spare_r    <= 1'b0;
      comb_grn_r <= 1'b0;
      comb_yel_r <= 1'b0;
      wred_r     <= 1'b0;
      wgrn_r     <= 1'b0;
      opt_r      <= 1'b0;
      bar_r      <= 2'h0;
    end else begin
      pwr_yel_r  <= pwr_yel_nxt;
      pwr_blu_r  <= pwr_blu_nxt;
      sync_r     <= sync_nxt;
      sess_r     <= sess_nxt;
      spare_r    <= spare_nxt;
      comb_grn_r <= comb_grn_nxt;
      comb_yel_r <= comb_yel_nxt;
      wred_r     <= wred_nxt;
      wgrn_r     <= wgrn_nxt;
      opt_r      <= opt_nxt;
      bar_r      <= bar_nxt;
    end
  end

  // ****************************************
  // status readback and outputs
  // ****************************************
  always_comb begin
    status_word                                  = 32'h0;
    status_word[sld_pkg::ST_POWER_YEL]           = pwr_yel_r;
    status_word[sld_pkg::ST_POWER_BLU]           = pwr_blu_r;
    status_word[sld_pkg::ST_SYNC]                = sync_r;
    status_word[sld_pkg::ST_SESSION]             = sess_r;
    status_word[sld_pkg::ST_SPARE]               = spare_r;
    status_word[sld_pkg::ST_COMB_GRN]            = comb_grn_r;
    status_word[sld_pkg::ST_COMB_YEL]            = comb_yel_r;
    status_word[sld_pkg::ST_WIRED_RED]           = wred_r;
    status_word[sld_pkg::ST_WIRED_GRN]           = wgrn_r;
    status_word[sld_pkg::ST_OPTICAL]             = opt_r;
    status_word[sld_pkg::ST_BAR_LSB +: 2]        = bar_r;
    status_word[sld_pkg::ST_ACTIVITY]            = act_busy;
  end

  assign prdata                       = prdata_r;
  assign pready                       = pready_r;
  assign pslverr                      = pslverr_r;
  assign power_indicator_yellow       = pwr_yel_r;
  assign power_indicator_blue         = pwr_blu_r;
  assign sync_lamp                    = sync_r;
  assign session_lamp                 = sess_r;
  assign spare_bar_lamp               = spare_r;
  assign combined_session_lamp_green  = comb_grn_r;
  assign combined_session_lamp_yellow = comb_yel_r;
  assign wired_link_lamp_red          = wred_r;
  assign wired_link_lamp_green        = wgrn_r;
  assign optical_port_lamp            = opt_r;

endmodule

`default_nettype wire
